// ==== hdl/acm_pkg.sv ====
// constants and types of the converter channel control block
//----------------------------------------------------------------------
// Functional notes
// - internal mode: positive codes 0-3 are internal sources, rest reserved
// - single-ended or differential: positive codes 0-11 pick pins 0-11
// - differential with gain: positive codes 0-7 only, top bit reserved
// - negative select only used in differential modes, ignored otherwise
// - differential without gain: negative codes 0-3 pick pins 0-3
// - differential with gain: negative codes 0-3 pick pins 4-7
// - condition: 00 complete, 01 below, 11 above, 10 reserved
// - priority field enables request at its level while flag set
// - flag set on completion, or only if configured compare holds
// - flag cleared by vector execution or by writing one
// - signed results are two's complement, top bit is sign
// - left adjusted: high gets 11:4, low upper nibble gets 3:0
// - right adjusted: high low nibble gets 11:8, low gets 7:0
// - right adjusted: high upper nibble is sign copy or zero
// - 8-bit: low byte result, high byte sign copy or zero
// - result pair read as one 16-bit value of one conversion
//----------------------------------------------------------------------
package acm_pkg;

  // register indices; byte address is four times the index
  localparam logic [3:0] IDX_CHANNEL_CONTROL  = 4'h0;
  localparam logic [3:0] IDX_INPUT_MUX_SELECT = 4'h1;
  localparam logic [3:0] IDX_IRQ_CONTROL      = 4'h2;
  localparam logic [3:0] IDX_IRQ_FLAG         = 4'h3;
  localparam logic [3:0] IDX_RESULT_LOW       = 4'h4;
  localparam logic [3:0] IDX_RESULT_HIGH      = 4'h5;
  localparam logic [3:0] IDX_CONVERT_CONFIG   = 4'h6;

  // field positions
  localparam int POS_INPUT_MODE  = 0;
  localparam int POS_NEG_SELECT  = 0;
  localparam int POS_POS_SELECT  = 3;
  localparam int POS_IRQ_LEVEL   = 0;
  localparam int POS_IRQ_COND    = 2;
  localparam int POS_IRQ_FLAG    = 0;
  localparam int POS_SIGNED_SEL  = 0;
  localparam int POS_RESOLUTION  = 1;

  // reset values
  localparam logic [7:0] RST_REG8   = 8'h00;
  localparam logic [7:0] RST_RESULT = 8'h00;

  // highest legal pin codes, and the first negative pin in gain mode
  localparam logic [3:0] POS_PIN_MAX  = 4'hB;
  localparam logic [3:0] POS_INT_MAX  = 4'h3;
  localparam logic [3:0] NEG_GAIN_BASE = 4'h4;

  // axi response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ACM_MODE_INTERNAL,
    ACM_MODE_SINGLE,
    ACM_MODE_DIFF,
    ACM_MODE_DIFF_GAIN
  } acm_input_mode_t;

  typedef enum logic [1:0] {
    ACM_COND_COMPLETE,
    ACM_COND_BELOW,
    ACM_COND_RESERVED,
    ACM_COND_ABOVE
  } acm_cond_t;

  typedef enum logic [1:0] {
    ACM_RES_12_RIGHT,
    ACM_RES_RESERVED,
    ACM_RES_8_BIT,
    ACM_RES_12_LEFT
  } acm_res_t;

  // routing towards the analog front end
  typedef struct packed {
    logic       pos_internal;
    logic [3:0] pos_code;
    logic       neg_used;
    logic [3:0] neg_pin;
    logic       code_reserved;
  } acm_route_t;

  // formatted result pair
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } acm_result_t;

endpackage : acm_pkg

// ==== hdl/acm_channel.sv ====
// converter channel control: input routing, flag, request, result format
`timescale 1ns/10ps
module acm_channel #(
  parameter int RESULT_W = 12
) (
  // clock and reset
  input  wire logic               aclk,
  input  wire logic               aresetn,
  // axi4-lite write address
  input  wire logic [5:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  // axi4-lite write response
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  // axi4-lite read address
  input  wire logic [5:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  // axi4-lite read data
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  // converter side
  input  wire logic               conv_done,
  input  wire logic [RESULT_W-1:0] result_word,
  input  wire logic [RESULT_W-1:0] compare_threshold,
  // interrupt controller side
  input  wire logic               irq_vector_taken,
  output logic [1:0]              irq_request_level,
  // analog routing
  output acm_pkg::acm_route_t     route
);

  //--------------------------------------------------------------------
  // elaboration check
  //--------------------------------------------------------------------
  if (RESULT_W != 12) begin : g_bad_width
    $error("acm_channel: RESULT_W must be 12");
  end

  //--------------------------------------------------------------------
  // register state
  //--------------------------------------------------------------------
  acm_pkg::acm_input_mode_t input_mode_select_q;
  logic [3:0]           positive_input_select_q;
  logic [1:0]           negative_input_select_q;
  acm_pkg::acm_cond_t   irq_condition_select_q;
  logic [1:0]           irq_priority_level_q;
  logic                 irq_flag_q;
  logic                 signed_conversion_select_q;
  acm_pkg::acm_res_t    resolution_q;
  acm_pkg::acm_result_t result_q;
  logic [7:0]           high_temp_q;

  //--------------------------------------------------------------------
  // bus state
  //--------------------------------------------------------------------
  logic [3:0]  aw_idx_q;
  logic        aw_hit_q;
  logic [7:0]  w_byte_q;
  logic        w_lane_q;
  logic        wr_fire;
  logic [3:0]  ar_idx;
  logic        ar_fire;
  logic [7:0]  rd_byte;
  logic        rd_hit;

  //--------------------------------------------------------------------
  // write channels: each taken once, then held until response
  //--------------------------------------------------------------------
  // a write happens only once both halves are held and no answer waits
  assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  // write address ready and capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      aw_idx_q      <= 4'h0;
      aw_hit_q      <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_idx_q      <= s_axi_awaddr[5:2];
      aw_hit_q      <= s_axi_awaddr[5:2] <= acm_pkg::IDX_CONVERT_CONFIG;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  // write data ready and capture; only byte lane 0 carries a register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b1;
      w_byte_q     <= 8'h00;
      w_lane_q     <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_byte_q     <= s_axi_wdata[7:0];
      w_lane_q     <= s_axi_wstrb[0];
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= acm_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= aw_hit_q ? acm_pkg::RESP_OKAY
                               : acm_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  //--------------------------------------------------------------------
  // control registers
  //--------------------------------------------------------------------
  // reserved bits are simply not stored, so they always read zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      input_mode_select_q        <= acm_pkg::ACM_MODE_INTERNAL;
      positive_input_select_q    <= 4'h0;
      negative_input_select_q    <= 2'h0;
      irq_condition_select_q     <= acm_pkg::ACM_COND_COMPLETE;
      irq_priority_level_q       <= 2'h0;
      signed_conversion_select_q <= 1'b0;
      resolution_q               <= acm_pkg::ACM_RES_12_RIGHT;
    end else if (wr_fire && w_lane_q) begin
      if (aw_idx_q == acm_pkg::IDX_CHANNEL_CONTROL) begin
        input_mode_select_q <= acm_pkg::acm_input_mode_t'(
          w_byte_q[acm_pkg::POS_INPUT_MODE +: 2]);
      end else if (aw_idx_q == acm_pkg::IDX_INPUT_MUX_SELECT) begin
        positive_input_select_q <=
          w_byte_q[acm_pkg::POS_POS_SELECT +: 4];
        negative_input_select_q <=
          w_byte_q[acm_pkg::POS_NEG_SELECT +: 2];
      end else if (aw_idx_q == acm_pkg::IDX_IRQ_CONTROL) begin
        irq_condition_select_q <= acm_pkg::acm_cond_t'(
          w_byte_q[acm_pkg::POS_IRQ_COND +: 2]);
        irq_priority_level_q <= w_byte_q[acm_pkg::POS_IRQ_LEVEL +: 2];
      end else if (aw_idx_q == acm_pkg::IDX_CONVERT_CONFIG) begin
        signed_conversion_select_q <= w_byte_q[acm_pkg::POS_SIGNED_SEL];
        resolution_q <= acm_pkg::acm_res_t'(
          w_byte_q[acm_pkg::POS_RESOLUTION +: 2]);
      end
    end
  end

  //--------------------------------------------------------------------
  // channel flag
  //--------------------------------------------------------------------
  logic cmp_below;
  logic cmp_above;
  logic flag_set;
  logic flag_clr;

  // signed compare when the conversion is signed
  always_comb begin
    if (signed_conversion_select_q) begin
      cmp_below = $signed(result_word) < $signed(compare_threshold);
      cmp_above = $signed(result_word) > $signed(compare_threshold);
    end else begin
      cmp_below = result_word < compare_threshold;
      cmp_above = result_word > compare_threshold;
    end
  end

  // set condition per configured mode; reserved mode never sets
  always_comb begin
    flag_set = 1'b0;
    if (conv_done) begin
      case (irq_condition_select_q)
        acm_pkg::ACM_COND_COMPLETE: flag_set = 1'b1;
        acm_pkg::ACM_COND_BELOW:    flag_set = cmp_below;
        acm_pkg::ACM_COND_ABOVE:    flag_set = cmp_above;
        default:                    flag_set = 1'b0;
      endcase
    end
  end

  // clear by vector execution or write-one
  assign flag_clr = irq_vector_taken
                  || (wr_fire && w_lane_q
                      && aw_idx_q == acm_pkg::IDX_IRQ_FLAG
                      && w_byte_q[acm_pkg::POS_IRQ_FLAG]);

  // a new event in the clearing cycle wins so it is not lost
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_flag_q <= 1'b0;
    end else if (flag_set) begin
      irq_flag_q <= 1'b1;
    end else if (flag_clr) begin
      irq_flag_q <= 1'b0;
    end
  end

  //--------------------------------------------------------------------
  // interrupt request
  //--------------------------------------------------------------------
  // level zero keeps the request quiet even with the flag up
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_request_level <= 2'h0;
    end else if (irq_flag_q && irq_priority_level_q != 2'h0) begin
      irq_request_level <= irq_priority_level_q;
    end else begin
      irq_request_level <= 2'h0;
    end
  end

  //--------------------------------------------------------------------
  // input routing decode
  //--------------------------------------------------------------------
  acm_pkg::acm_route_t route_d;

  always_comb begin
    route_d          = '0;
    route_d.pos_code = positive_input_select_q;
    case (input_mode_select_q)
      acm_pkg::ACM_MODE_INTERNAL: begin
        route_d.pos_internal  = 1'b1;
        route_d.code_reserved =
          positive_input_select_q > acm_pkg::POS_INT_MAX;
      end
      acm_pkg::ACM_MODE_SINGLE: begin
        route_d.code_reserved =
          positive_input_select_q > acm_pkg::POS_PIN_MAX;
      end
      acm_pkg::ACM_MODE_DIFF: begin
        route_d.code_reserved =
          positive_input_select_q > acm_pkg::POS_PIN_MAX;
        route_d.neg_used = 1'b1;
        route_d.neg_pin  = {2'b00, negative_input_select_q};
      end
      default: begin
        route_d.code_reserved = positive_input_select_q[3];
        route_d.neg_used = 1'b1;
        route_d.neg_pin  = acm_pkg::NEG_GAIN_BASE
                         | {2'b00, negative_input_select_q};
      end
    endcase
  end

  // registered so the front end sees glitch-free selects
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      route <= '0;
    end else begin
      route <= route_d;
    end
  end

  //--------------------------------------------------------------------
  // result formatting
  //--------------------------------------------------------------------
  acm_pkg::acm_result_t result_d;
  logic                 sign11;
  logic                 sign7;

  // sign copies only in signed conversion, zeros otherwise
  assign sign11 = signed_conversion_select_q & result_word[11];
  assign sign7  = signed_conversion_select_q & result_word[7];

  always_comb begin
    case (resolution_q)
      acm_pkg::ACM_RES_12_LEFT: begin
        result_d.high = result_word[11:4];
        result_d.low  = {result_word[3:0], 4'h0};
      end
      acm_pkg::ACM_RES_8_BIT: begin
        result_d.high = {8{sign7}};
        result_d.low  = result_word[7:0];
      end
      default: begin
        result_d.high = {{4{sign11}}, result_word[11:8]};
        result_d.low  = result_word[7:0];
      end
    endcase
  end

  // both bytes captured on the same edge from one conversion
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_q <= {acm_pkg::RST_RESULT, acm_pkg::RST_RESULT};
    end else if (conv_done) begin
      result_q <= result_d;
    end
  end

  //--------------------------------------------------------------------
  // read channel
  //--------------------------------------------------------------------
  assign ar_idx  = s_axi_araddr[5:2];
  assign ar_fire = s_axi_arvalid && s_axi_arready;

  // read decode; result registers are never written
  always_comb begin
    rd_byte = 8'h00;
    rd_hit  = 1'b1;
    if (ar_idx == acm_pkg::IDX_CHANNEL_CONTROL) begin
      rd_byte[acm_pkg::POS_INPUT_MODE +: 2] = input_mode_select_q;
    end else if (ar_idx == acm_pkg::IDX_INPUT_MUX_SELECT) begin
      rd_byte[acm_pkg::POS_POS_SELECT +: 4] = positive_input_select_q;
      rd_byte[acm_pkg::POS_NEG_SELECT +: 2] = negative_input_select_q;
    end else if (ar_idx == acm_pkg::IDX_IRQ_CONTROL) begin
      rd_byte[acm_pkg::POS_IRQ_COND +: 2]  = irq_condition_select_q;
      rd_byte[acm_pkg::POS_IRQ_LEVEL +: 2] = irq_priority_level_q;
    end else if (ar_idx == acm_pkg::IDX_IRQ_FLAG) begin
      rd_byte[acm_pkg::POS_IRQ_FLAG] = irq_flag_q;
    end else if (ar_idx == acm_pkg::IDX_RESULT_LOW) begin
      rd_byte = result_q.low;
    end else if (ar_idx == acm_pkg::IDX_RESULT_HIGH) begin
      rd_byte = high_temp_q;
    end else if (ar_idx == acm_pkg::IDX_CONVERT_CONFIG) begin
      rd_byte[acm_pkg::POS_SIGNED_SEL]      = signed_conversion_select_q;
      rd_byte[acm_pkg::POS_RESOLUTION +: 2] = resolution_q;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // reading the low byte freezes the high byte for the next read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      high_temp_q <= acm_pkg::RST_RESULT;
    end else if (ar_fire && ar_idx == acm_pkg::IDX_RESULT_LOW) begin
      high_temp_q <= result_q.high;
    end
  end

  // read address ready; one read outstanding at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
    end else if (ar_fire) begin
      s_axi_arready <= 1'b0;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
    end
  end

  // read data, answered on the same edge that takes the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= acm_pkg::RESP_OKAY;
    end else if (ar_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h00_0000, rd_byte};
      s_axi_rresp  <= rd_hit ? acm_pkg::RESP_OKAY
                             : acm_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : acm_channel

// ==== verification/acm_monitor.sv ====
// assertion checker for the converter channel control block
`timescale 1ns/10ps
module acm_monitor (
  // clock and reset
  input wire logic                aclk,
  input wire logic                aresetn,
  // register bus
  input wire logic                s_axi_awvalid,
  input wire logic                s_axi_awready,
  input wire logic                s_axi_wvalid,
  input wire logic                s_axi_wready,
  input wire logic                s_axi_bvalid,
  input wire logic [5:0]          s_axi_araddr,
  input wire logic                s_axi_arvalid,
  input wire logic                s_axi_arready,
  input wire logic [31:0]         s_axi_rdata,
  input wire logic [1:0]          s_axi_rresp,
  input wire logic                s_axi_rvalid,
  // converter, interrupt and routing
  input wire logic                conv_done,
  input wire logic                irq_vector_taken,
  input wire logic [1:0]          irq_request_level,
  input wire acm_pkg::acm_route_t route
);
  // --------
  // shared clocking; nothing is judged while reset is low
  // --------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // both halves taken together: readies drop, answer one edge later
  chk_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid)
    else $error("write answer wrong");
  chk_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer wrong");
  // holes in the map answer with an error and zero data
  chk_unmapped_error: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr[5:2] > 4'h6
    |=> s_axi_rresp == acm_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  chk_upper_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  chk_flag_reserved: assert property (
    s_axi_arvalid && s_axi_arready
    && s_axi_araddr[5:2] == acm_pkg::IDX_IRQ_FLAG
    |=> s_axi_rdata[7:1] == 7'h00)
    else $error("flag reserved bits set");
  // a new conversion in the same cycle would win, so it is excluded
  chk_vector_clears: assert property (
    irq_vector_taken && !conv_done |-> ##2 irq_request_level == 2'h0)
    else $error("request survives vector");
  chk_route_internal: assert property (
    route.pos_internal |-> !route.neg_used && route.neg_pin == 4'h0
    && route.code_reserved == (route.pos_code > 4'h3))
    else $error("internal routing wrong");
  chk_neg_range: assert property (
    route.neg_used |-> !route.pos_internal && route.neg_pin <= 4'h7)
    else $error("negative pin out of range");
  chk_reset_release: assert property (
    $rose(aresetn) |-> route == '0 && irq_request_level == 2'h0
    && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs not cleared by reset");

  // main scenarios reached
  cov_conversion: cover property (conv_done);
  cov_top_level: cover property (irq_request_level == 2'h3);
  cov_refused: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule : acm_monitor

// ==== verification/testbench.sv ====
// self-checking bench for the converter channel control block
`timescale 1ns/10ps
module testbench;
  // --------
  // signals, stimulus tables and the device
  // --------
  logic        aclk, aresetn, conv_done, irq_vector_taken;
  logic [5:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, irq_request_level, rsp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [11:0] result_word, compare_threshold;
  logic [7:0]  rd;
  acm_pkg::acm_route_t route;
  int          miscompares, samples_checked;
  // config byte, raw result, expected pair
  logic [35:0] fmt_tab [8] = '{
    {8'h00, 12'hABC, 16'h0ABC}, {8'h01, 12'hABC, 16'hFABC},
    {8'h01, 12'h7BC, 16'h07BC}, {8'h06, 12'hABC, 16'hABC0},
    {8'h07, 12'h5A3, 16'h5A30}, {8'h04, 12'h0A5, 16'h00A5},
    {8'h05, 12'h0A5, 16'hFFA5}, {8'h05, 12'h055, 16'h0055}};
  // condition, raw result, expected flag; threshold 0x100, signed
  logic [15:0] cmp_tab [8] = '{
    {2'h1, 12'h0FF, 2'h1}, {2'h1, 12'h100, 2'h0}, {2'h3, 12'h101, 2'h1},
    {2'h3, 12'h100, 2'h0}, {2'h2, 12'h000, 2'h0}, {2'h2, 12'hFFF, 2'h0},
    {2'h3, 12'hFFF, 2'h0}, {2'h0, 12'h100, 2'h1}};
  // mode, positive, negative, expected routing word
  logic [18:0] route_tab [8] = '{
    {2'h0, 4'h2, 2'h3, 1'b1, 4'h2, 1'b0, 4'h0, 1'b0},
    {2'h0, 4'h4, 2'h0, 1'b1, 4'h4, 1'b0, 4'h0, 1'b1},
    {2'h1, 4'hB, 2'h3, 1'b0, 4'hB, 1'b0, 4'h0, 1'b0},
    {2'h1, 4'hC, 2'h0, 1'b0, 4'hC, 1'b0, 4'h0, 1'b1},
    {2'h2, 4'hB, 2'h2, 1'b0, 4'hB, 1'b1, 4'h2, 1'b0},
    {2'h2, 4'hC, 2'h1, 1'b0, 4'hC, 1'b1, 4'h1, 1'b1},
    {2'h3, 4'h7, 2'h3, 1'b0, 4'h7, 1'b1, 4'h7, 1'b0},
    {2'h3, 4'h8, 2'h0, 1'b0, 4'h8, 1'b1, 4'h4, 1'b1}};

  acm_channel #(.RESULT_W(12)) dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .conv_done(conv_done), .result_word(result_word),
    .compare_threshold(compare_threshold),
    .irq_vector_taken(irq_vector_taken),
    .irq_request_level(irq_request_level), .route(route));

  // --------
  // bus cycles and comparisons
  // --------
  task automatic cmp_val(input string nm, input logic [15:0] e,
                         input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_val

  // address and data together; each drops when taken
  task automatic axi_write(input logic [3:0] idx, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr  <= {idx, 2'b00};
    s_axi_wdata   <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [3:0] idx);
    @(posedge aclk);
    s_axi_araddr  <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata[7:0];
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_read

  // low byte first; that read freezes the high byte
  task automatic read_pair(output logic [15:0] v);
    axi_read(acm_pkg::IDX_RESULT_LOW);
    v[7:0] = rd;
    axi_read(acm_pkg::IDX_RESULT_HIGH);
    v[15:8] = rd;
  endtask : read_pair

  task automatic convert(input logic [11:0] v);
    @(posedge aclk);
    result_word <= v;
    conv_done   <= 1'b1;
    @(posedge aclk);
    conv_done   <= 1'b0;
  endtask : convert

  // --------
  // scenarios
  // --------
  // reset state, then writes to result bytes
  task automatic t_reset_values();
    logic [15:0] v;
    cmp_val("route", 16'h0000, {5'h00, route});
    cmp_val("request", 16'h0000, {14'h0, irq_request_level});
    for (int i = 0; i < 16; i++) begin
      axi_read(i[3:0]);
      cmp_val("reset read", {6'h00, (i > 6) ? 2'h2 : 2'h0, 8'h00},
              {6'h00, rsp, rd});
    end
    axi_write(acm_pkg::IDX_RESULT_LOW, 8'hFF);
    cmp_val("low write resp", 16'h0000, {14'h0, rsp});
    axi_write(acm_pkg::IDX_RESULT_HIGH, 8'hFF);
    read_pair(v);
    cmp_val("result untouched", 16'h0000, v);
  endtask : t_reset_values

  task automatic t_formats();
    logic [15:0] v;
    logic [35:0] e;
    for (int i = 0; i < 8; i++) begin
      e = fmt_tab[i];
      axi_write(acm_pkg::IDX_CONVERT_CONFIG, e[35:28]);
      convert(e[27:16]);
      read_pair(v);
      cmp_val("result", e[15:0], v);
    end
    axi_write(acm_pkg::IDX_CONVERT_CONFIG, 8'h01);
    convert(12'h123);
    axi_read(acm_pkg::IDX_RESULT_LOW);
    convert(12'h456);
    axi_read(acm_pkg::IDX_RESULT_HIGH);
    cmp_val("high after low", 16'h0001, {8'h00, rd});
  endtask : t_formats

  // every level, write-zero, write-one and vector clearing
  task automatic t_irq();
    axi_write(acm_pkg::IDX_IRQ_FLAG, 8'h01);
    for (int l = 0; l < 4; l++) begin
      axi_write(acm_pkg::IDX_IRQ_CONTROL, {6'h00, l[1:0]});
      convert(12'h321);
      axi_read(acm_pkg::IDX_IRQ_FLAG);
      cmp_val("flag", 16'h0001, {8'h00, rd});
      cmp_val("level", {14'h0, l[1:0]}, {14'h0, irq_request_level});
      axi_write(acm_pkg::IDX_IRQ_FLAG, 8'h00);
      axi_read(acm_pkg::IDX_IRQ_FLAG);
      cmp_val("flag kept", 16'h0001, {8'h00, rd});
      axi_write(acm_pkg::IDX_IRQ_FLAG, 8'h01);
      @(posedge aclk);
      cmp_val("request off", 16'h0000, {14'h0, irq_request_level});
    end
    convert(12'h321);
    @(posedge aclk);
    irq_vector_taken <= 1'b1;
    @(posedge aclk);
    irq_vector_taken <= 1'b0;
    axi_read(acm_pkg::IDX_IRQ_FLAG);
    cmp_val("vector clear", 16'h0000, {8'h00, rd});
  endtask : t_irq

  task automatic t_compare();
    logic [15:0] e;
    compare_threshold <= 12'h100;
    for (int i = 0; i < 8; i++) begin
      e = cmp_tab[i];
      axi_write(acm_pkg::IDX_IRQ_CONTROL, {4'h0, e[15:14], 2'h1});
      axi_write(acm_pkg::IDX_IRQ_FLAG, 8'h01);
      convert(e[13:2]);
      axi_read(acm_pkg::IDX_IRQ_FLAG);
      cmp_val("compare flag", {15'h0, e[0]}, {8'h00, rd});
    end
  endtask : t_compare

  // routing settles one edge after the write lands
  task automatic t_route();
    logic [18:0] r;
    for (int i = 0; i < 8; i++) begin
      r = route_tab[i];
      axi_write(acm_pkg::IDX_CHANNEL_CONTROL, {6'h00, r[18:17]});
      axi_write(acm_pkg::IDX_INPUT_MUX_SELECT,
                {1'b0, r[16:13], 1'b0, r[12:11]});
      @(posedge aclk);
      cmp_val("route", {5'h00, r[10:0]}, {5'h00, route});
    end
  endtask : t_route

  task automatic print_verdict();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict

  // --------
  // clock, main sequence and watchdog
  // --------
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  initial begin
    aresetn = 1'b0;
    s_axi_wstrb = 4'h1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, result_word} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, conv_done, irq_vector_taken} = '0;
    {compare_threshold, miscompares, samples_checked} = '0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset_values();
    t_formats();
    t_irq();
    t_compare();
    t_route();
    print_verdict();
  end

  // the sequence needs well under two thousand cycles
  initial begin
    repeat (6000) @(posedge aclk);
    miscompares++;
    print_verdict();
  end
endmodule : testbench

bind acm_channel acm_monitor u_monitor (
  .aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .conv_done(conv_done),
  .irq_vector_taken(irq_vector_taken),
  .irq_request_level(irq_request_level), .route(route));
